// File: src/phase_sync_cfg_pkg.sv
// Package of offsets, field positions, reset values and timing counts
package phase_sync_cfg_pkg;
    // Register offsets on the serial port address space
    localparam logic [6:0] OFS_COARSE_CFG = 7'h74;
    localparam logic [6:0] OFS_NOISE_CFG = 7'h76;
    localparam logic [6:0] OFS_PHASE_LO = 7'h77;
    localparam logic [6:0] OFS_PHASE_HI = 7'h78;
    localparam logic [6:0] OFS_ALARM_CFG = 7'h79;
    localparam logic [6:0] OFS_SYNC_CFG = 7'h7A;
    localparam logic [6:0] OFS_ALIGN_CFG = 7'h7B;
    // Reset values
    localparam logic [7:0] RST_COARSE_CFG = 8'h85;
    localparam logic [7:0] RST_NOISE_CFG = 8'h06;
    localparam logic [7:0] RST_ALARM_CFG = 8'h32;
    localparam logic [7:0] RST_SYNC_CFG = 8'h00;
    localparam logic [7:0] RST_ALIGN_CFG = 8'h00;
    // Field positions
    localparam int BIT_WIDE_RANGE = 6;
    localparam int BIT_MULTICYCLE = 5;
    localparam int BIT_WINDOW_ON = 7;
    localparam int BIT_SYNC_SRC = 7;
    localparam int BIT_FS_FLIP = 3;
    localparam int BIT_FS_PULSED = 2;
    localparam int BIT_MFS_FLIP = 1;
    localparam int BIT_MFS_PULSED = 0;
    // Coarse range codes
    localparam logic [3:0] RANGE_CODE_MAX = 4'hC;
    // Alarm timing: one timeout unit is two seconds
    localparam int CLK_HZ = 25000000;
    localparam int UNIT_S = 2;
    localparam int UNIT_CYCLES = CLK_HZ * UNIT_S;
    // Noise window: five percent of the expected edge period
    localparam int WINDOW_PCT = 5;
endpackage : phase_sync_cfg_pkg

// File: src/phase_sync_cfg.sv
// DPLL phase detector configuration, phase readback, alarm timing and sync outputs
`timescale 1ns/1ps
module phase_sync_cfg
#(
    parameter int UNIT_CYCLES_P = phase_sync_cfg_pkg::UNIT_CYCLES,
    parameter int EDGE_W = 24
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Phase detector results of both loops
    input wire logic [15:0] i_first_loop_phase,
    input wire logic [15:0] i_second_loop_phase,
    input wire logic i_phase_loop_select,
    input wire logic [31:0] i_coarse_phase,
    // Low-frequency input edges
    input wire logic i_lf_edge,
    input wire logic [EDGE_W-1:0] i_lf_period,
    // Controller state and alarm control
    input wire logic i_unlocked_state,
    input wire logic i_alarm_clear,
    input wire logic i_alarm_expire_en,
    // Sync sources
    input wire logic i_first_loop_fs,
    input wire logic i_first_loop_mfs,
    input wire logic i_second_loop_fs,
    input wire logic i_second_loop_mfs,
    input wire logic i_second_clock_output_tick,
    output logic o_wide_range_on,
    output logic [31:0] o_loop_phase,
    output logic [13:0] o_track_range,
    output logic o_edge_valid,
    output logic o_phase_alarm,
    output logic o_frame_sync_out,
    output logic o_multiframe_sync_out,
    output logic [7:0] o_align_cfg
);
    import phase_sync_cfg_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] coarse;
        logic [7:0] noise;
        logic [7:0] alarm_cfg;
        logic [7:0] sync;
        logic [7:0] align;
        logic [15:0] snap;
        logic [7:0] rdata;
        logic wide;
        logic [31:0] loop_phase;
        logic [13:0] range;
        logic [EDGE_W-1:0] since_edge;
        logic edge_ok;
        logic [31:0] tick_cnt;
        logic [5:0] units;
        logic alarm;
        logic [1:0] fs_prev;
        logic fs_pulse_live;
        logic mfs_pulse_live;
        logic fs_out;
        logic mfs_out;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    logic [15:0] sel_phase;
    logic fs_src;
    logic mfs_src;
    logic [EDGE_W-1:0] tol;
    logic [EDGE_W-1:0] lo_lim;
    logic [EDGE_W-1:0] hi_lim;
    logic [31:0] clip;

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    // Loop and source selection
    always_comb
    begin
        sel_phase = i_phase_loop_select ? i_second_loop_phase : i_first_loop_phase;
        fs_src = st_ff.sync[BIT_SYNC_SRC] ? i_second_loop_fs : i_first_loop_fs;
        mfs_src = st_ff.sync[BIT_SYNC_SRC] ? i_second_loop_mfs : i_first_loop_mfs;
        tol = EDGE_W'((i_lf_period * WINDOW_PCT) / 100);
        lo_lim = i_lf_period - tol;
        hi_lim = i_lf_period + tol;
        clip = 32'h0000FFFF;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        // Register writes
        if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                OFS_COARSE_CFG: nxt_st.coarse = i_reg_wdata;
                OFS_NOISE_CFG: nxt_st.noise = i_reg_wdata;
                OFS_ALARM_CFG: nxt_st.alarm_cfg = i_reg_wdata;
                OFS_SYNC_CFG: nxt_st.sync = i_reg_wdata;
                OFS_ALIGN_CFG: nxt_st.align = i_reg_wdata;
                default: ;
            endcase
        end
        // Snapshot low byte read so the high byte matches it
        if (i_reg_rd && i_reg_addr == OFS_PHASE_LO)
        begin
            nxt_st.snap = sel_phase;
        end
        // Read data, unmapped reads zero
        nxt_st.rdata = 8'h00;
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                OFS_COARSE_CFG: nxt_st.rdata = st_ff.coarse;
                OFS_NOISE_CFG: nxt_st.rdata = {st_ff.noise[7], 7'h06};
                OFS_PHASE_LO: nxt_st.rdata = sel_phase[7:0];
                OFS_PHASE_HI: nxt_st.rdata = st_ff.snap[15:8];
                OFS_ALARM_CFG: nxt_st.rdata = {2'h0, st_ff.alarm_cfg[5:0]};
                OFS_SYNC_CFG: nxt_st.rdata = {st_ff.sync[7], 3'h0, st_ff.sync[3:0]};
                OFS_ALIGN_CFG: nxt_st.rdata = st_ff.align;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        // Detector setup
        nxt_st.wide = st_ff.coarse[BIT_WIDE_RANGE];
        if (st_ff.coarse[3:0] >= RANGE_CODE_MAX)
        begin
            nxt_st.range = 14'h1FFF;
        end
        else
        begin
            nxt_st.range = 14'((32'h2 << st_ff.coarse[3:0]) - 1);
        end
        if (st_ff.coarse[BIT_MULTICYCLE])
        begin
            nxt_st.loop_phase = i_coarse_phase;
        end
        else
        begin
            nxt_st.loop_phase = {16'h0000, i_coarse_phase[15:0] & clip[15:0]};
        end
        // Edge window filter
        nxt_st.edge_ok = 1'b0;
        if (i_lf_edge)
        begin
            nxt_st.since_edge = EDGE_W'(1); // Edge cycle counts as one
            nxt_st.edge_ok = !st_ff.noise[BIT_WINDOW_ON] ||
                (st_ff.since_edge >= lo_lim && st_ff.since_edge <= hi_lim);
        end
        else if (st_ff.since_edge != {EDGE_W{1'b1}})
        begin
            nxt_st.since_edge = st_ff.since_edge + 1'b1;
        end
        // Alarm timeout in two-second units
        if (!i_unlocked_state || st_ff.alarm)
        begin
            nxt_st.tick_cnt = '0;
            nxt_st.units = '0;
        end
        else if (st_ff.tick_cnt == 32'(UNIT_CYCLES_P - 1))
        begin
            nxt_st.tick_cnt = '0;
            nxt_st.units = st_ff.units + 6'h01;
        end
        else
        begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
        end
        // Sticky alarm: raise wins over clear
        if (i_unlocked_state && !st_ff.alarm && st_ff.units >= st_ff.alarm_cfg[5:0])
        begin
            nxt_st.alarm = 1'b1;
        end
        else if (i_alarm_clear || (i_alarm_expire_en && !i_unlocked_state))
        begin
            nxt_st.alarm = 1'b0;
        end
        // Sync outputs: pulse spans one second clock output period
        nxt_st.fs_prev = {fs_src, mfs_src};
        if (fs_src && !st_ff.fs_prev[1])
        begin
            nxt_st.fs_pulse_live = 1'b1;
        end
        else if (i_second_clock_output_tick)
        begin
            nxt_st.fs_pulse_live = 1'b0;
        end
        if (mfs_src && !st_ff.fs_prev[0])
        begin
            nxt_st.mfs_pulse_live = 1'b1;
        end
        else if (i_second_clock_output_tick)
        begin
            nxt_st.mfs_pulse_live = 1'b0;
        end
        nxt_st.fs_out = (st_ff.sync[BIT_FS_PULSED] ? st_ff.fs_pulse_live : fs_src)
            ^ st_ff.sync[BIT_FS_FLIP];
        nxt_st.mfs_out = (st_ff.sync[BIT_MFS_PULSED] ? st_ff.mfs_pulse_live : mfs_src)
            ^ st_ff.sync[BIT_MFS_FLIP];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            st_ff <= '0;
            st_ff.coarse <= RST_COARSE_CFG;
            st_ff.noise <= RST_NOISE_CFG;
            st_ff.alarm_cfg <= RST_ALARM_CFG;
            st_ff.sync <= RST_SYNC_CFG;
            st_ff.align <= RST_ALIGN_CFG;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign o_reg_rdata = st_ff.rdata;
    assign o_wide_range_on = st_ff.wide;
    assign o_loop_phase = st_ff.loop_phase;
    assign o_track_range = st_ff.range;
    assign o_edge_valid = st_ff.edge_ok;
    assign o_phase_alarm = st_ff.alarm;
    assign o_frame_sync_out = st_ff.fs_out;
    assign o_multiframe_sync_out = st_ff.mfs_out;
    assign o_align_cfg = st_ff.align;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_WIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_wide_range_on == $past(st_ff.coarse[BIT_WIDE_RANGE]))
        else $error("wide range enable not following its bit");
    AST_CLIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !$past(st_ff.coarse[BIT_MULTICYCLE]) |-> o_loop_phase[31:16] == 16'h0000)
        else $error("phase not clipped with multicycle off");
    AST_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(st_ff.coarse[3:0]) == 4'h9 |-> o_track_range == 14'd1023)
        else $error("code 1001 not 1023 UI");
    AST_WINDOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(i_lf_edge) && !$past(st_ff.noise[BIT_WINDOW_ON]) |-> o_edge_valid)
        else $error("edge dropped with window off");
    AST_HIBYTE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_reg_rd && i_reg_addr == OFS_PHASE_LO |=> st_ff.snap == $past(sel_phase))
        else $error("phase snapshot missed");
    AST_ALARM_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_phase_alarm && !i_alarm_clear && !i_alarm_expire_en |=> o_phase_alarm)
        else $error("alarm dropped without clear");
    AST_NO_EARLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_phase_alarm) |-> $past(st_ff.units) >= $past(st_ff.alarm_cfg[5:0]))
        else $error("alarm before timeout");
    AST_FLIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !$past(st_ff.sync[BIT_FS_PULSED]) |->
        o_frame_sync_out == ($past(fs_src) ^ $past(st_ff.sync[BIT_FS_FLIP])))
        else $error("frame sync polarity wrong");
    AST_PULSE_END: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.fs_pulse_live && i_second_clock_output_tick && !(fs_src && !st_ff.fs_prev[1])
        |=> !st_ff.fs_pulse_live)
        else $error("pulse longer than one period");
    AST_EDGE_REJECT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lf_edge && st_ff.noise[BIT_WINDOW_ON] && st_ff.since_edge < lo_lim |=> !o_edge_valid)
        else $error("early edge passed with window on");
    AST_ALARM_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_unlocked_state && !o_phase_alarm && st_ff.units >= st_ff.alarm_cfg[5:0]
        |=> o_phase_alarm)
        else $error("alarm not raised at timeout");
    AST_PULSE_START: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        fs_src && !st_ff.fs_prev[1] |=> st_ff.fs_pulse_live)
        else $error("frame sync pulse not started");
    AST_MFS_PULSE_END: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.mfs_pulse_live && i_second_clock_output_tick && !(mfs_src && !st_ff.fs_prev[0])
        |=> !st_ff.mfs_pulse_live)
        else $error("multiframe pulse longer than one period");
endmodule : phase_sync_cfg

// File: dv/phase_sync_cfg_test.sv
// Self-checking testbench of the phase detector configuration and sync output bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module phase_sync_cfg_test;
    import phase_sync_cfg_pkg::*;
    localparam int UNIT_SIM = 10;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [6:0] i_reg_addr = 7'h00;
    logic [6:0] adr;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, o_align_cfg, d, v;
    logic [15:0] i_first_loop_phase = 16'h0000, i_second_loop_phase = 16'h0000;
    logic [15:0] rnd = 16'h21EE; // Seed 8686
    logic [31:0] i_coarse_phase = 32'h00000000, o_loop_phase;
    logic i_phase_loop_select = 1'b0, i_lf_edge = 1'b0, i_unlocked_state = 1'b0;
    logic i_alarm_clear = 1'b0, i_alarm_expire_en = 1'b0, i_second_clock_output_tick = 1'b0;
    logic i_first_loop_fs = 1'b0, i_first_loop_mfs = 1'b0;
    logic i_second_loop_fs = 1'b0, i_second_loop_mfs = 1'b0;
    logic [23:0] i_lf_period = 24'h000064;
    logic o_wide_range_on, o_edge_valid, o_phase_alarm, o_frame_sync_out, o_multiframe_sync_out;
    logic [13:0] o_track_range;
    int mismatches = 0, tests_run = 0, cycles = 0;
    // ----------------------------------------
    // Design under test, short alarm unit
    // ----------------------------------------
    phase_sync_cfg #(.UNIT_CYCLES_P(UNIT_SIM), .EDGE_W(24)) dut_u (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_first_loop_phase(i_first_loop_phase), .i_second_loop_phase(i_second_loop_phase),
        .i_phase_loop_select(i_phase_loop_select), .i_coarse_phase(i_coarse_phase),
        .i_lf_edge(i_lf_edge), .i_lf_period(i_lf_period), .i_unlocked_state(i_unlocked_state),
        .i_alarm_clear(i_alarm_clear), .i_alarm_expire_en(i_alarm_expire_en),
        .i_first_loop_fs(i_first_loop_fs), .i_first_loop_mfs(i_first_loop_mfs),
        .i_second_loop_fs(i_second_loop_fs), .i_second_loop_mfs(i_second_loop_mfs),
        .i_second_clock_output_tick(i_second_clock_output_tick),
        .o_wide_range_on(o_wide_range_on), .o_loop_phase(o_loop_phase),
        .o_track_range(o_track_range), .o_edge_valid(o_edge_valid),
        .o_phase_alarm(o_phase_alarm), .o_frame_sync_out(o_frame_sync_out),
        .o_multiframe_sync_out(o_multiframe_sync_out), .o_align_cfg(o_align_cfg));
    // ----------------------------------------
    // Clock, hang guard and helpers
    // ----------------------------------------
    initial
    begin
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // Tracked window for a coarse code, saturating at the top codes
    function automatic logic [13:0] range_exp(input logic [3:0] c);
        return (c >= 4'hC) ? 14'h1FFF : 14'((32'h1 << (c + 1)) - 1);
    endfunction : range_exp
    // Read-back image of a written byte per offset
    function automatic logic [7:0] rb_exp(input logic [6:0] a, input logic [7:0] w);
        case (a)
            OFS_NOISE_CFG: return (w & 8'h80) | 8'h06;
            OFS_ALARM_CFG: return w & 8'h3F;
            OFS_SYNC_CFG: return w & 8'h8F;
            default: return w;
        endcase
    endfunction : rb_exp
    // Writable offsets in turn
    function automatic logic [6:0] rw_addr(input int k);
        case (k)
            0: return OFS_COARSE_CFG;
            1: return OFS_NOISE_CFG;
            2: return OFS_ALARM_CFG;
            3: return OFS_SYNC_CFG;
            default: return OFS_ALIGN_CFG;
        endcase
    endfunction : rw_addr
    // One low-frequency edge, gap cycles after the previous one
    task automatic lf_edge_after(input int gap);
        repeat (gap - 1) @(posedge i_clk);
        #1 i_lf_edge = 1'b1;
        @(posedge i_clk) #1 i_lf_edge = 1'b0;
    endtask : lf_edge_after
    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        @(posedge i_clk) #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, w};
        @(posedge i_clk) #1 i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] r);
        @(posedge i_clk) #1 {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(posedge i_clk) #1 i_reg_rd = 1'b0;
        r = o_reg_rdata;
    endtask : rd
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        // Reset values and unmapped or read-only places
        rd(OFS_COARSE_CFG, d); `CHK("coarse", RST_COARSE_CFG, d)
        rd(OFS_NOISE_CFG, d); `CHK("noise", RST_NOISE_CFG, d)
        rd(OFS_ALARM_CFG, d); `CHK("alarm cfg", RST_ALARM_CFG, d)
        rd(OFS_SYNC_CFG, d); `CHK("sync cfg", RST_SYNC_CFG, d)
        rd(OFS_ALIGN_CFG, d); `CHK("align", RST_ALIGN_CFG, d)
        wr(7'h75, 8'hFF); rd(7'h75, d); `CHK("unmapped", 8'h00, d)
        wr(OFS_PHASE_LO, 8'hFF); rd(OFS_PHASE_LO, d); `CHK("ro low", 8'h00, d)
        // Random read-write round trips, bit 4 of the coarse byte left clear
        for (int i = 0; i < 10; i++)
        begin
            rnd = lfsr_next(rnd);
            adr = rw_addr(i % 5);
            v = (i % 5 == 0) ? (rnd[7:0] & 8'hEF) : rnd[7:0];
            wr(adr, v);
            rd(adr, d);
            `CHK("rw", rb_exp(adr, v), d)
        end
        wr(OFS_ALIGN_CFG, 8'hA5); #41 `CHK("align out", 8'hA5, o_align_cfg)
        // Every coarse code with random wide-range and multicycle bits
        for (int c = 0; c < 16; c++)
        begin
            rnd = lfsr_next(rnd);
            i_coarse_phase = {rnd, ~rnd};
            v = {rnd[7:5], 1'b0, 4'(c)};
            wr(OFS_COARSE_CFG, v);
            repeat (3) @(posedge i_clk);
            #1 `CHK("range", range_exp(4'(c)), o_track_range)
            `CHK("wide", v[BIT_WIDE_RANGE], o_wide_range_on)
            if (v[BIT_MULTICYCLE])
                `CHK("phase full", i_coarse_phase, o_loop_phase)
            else
                `CHK("phase clip", {16'h0000, i_coarse_phase[15:0]}, o_loop_phase)
        end
        // Phase readback of each loop, low byte snapshots the pair
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr_next(rnd);
            {i_first_loop_phase, i_second_loop_phase} = {rnd, rnd ^ 16'h5A3C};
            i_phase_loop_select = 1'(i);
            rd(OFS_PHASE_LO, d);
            i_first_loop_phase = ~i_first_loop_phase;
            i_second_loop_phase = ~i_second_loop_phase;
            `CHK("phase lo", i_phase_loop_select ? ~i_second_loop_phase[7:0]
                : ~i_first_loop_phase[7:0], d)
            rd(OFS_PHASE_HI, d);
            `CHK("phase hi", i_phase_loop_select ? ~i_second_loop_phase[15:8]
                : ~i_first_loop_phase[15:8], d)
        end
        // Sync source and polarity in level mode
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr_next(rnd);
            {i_first_loop_fs, i_first_loop_mfs, i_second_loop_fs, i_second_loop_mfs} = rnd[11:8];
            wr(OFS_SYNC_CFG, rnd[7:0] & 8'h8A);
            repeat (3) @(posedge i_clk);
            #1 `CHK("fs", (rnd[7] ? rnd[9] : rnd[11]) ^ rnd[3], o_frame_sync_out)
            `CHK("mfs", (rnd[7] ? rnd[8] : rnd[10]) ^ rnd[1], o_multiframe_sync_out)
        end
        // Edge filter off passes every edge
        wr(OFS_NOISE_CFG, 8'h00);
        @(posedge i_clk) #1 i_lf_edge = 1'b1;
        @(posedge i_clk) #1 i_lf_edge = 1'b0;
        `CHK("edge", 1'b1, o_edge_valid)
        // Edge filter on: 100-cycle period gives a window of 95 to 105
        wr(OFS_NOISE_CFG, 8'h80);
        lf_edge_after(1);
        lf_edge_after(100); `CHK("edge on time", 1'b1, o_edge_valid)
        lf_edge_after(50); `CHK("edge early", 1'b0, o_edge_valid)
        lf_edge_after(95); `CHK("edge low bound", 1'b1, o_edge_valid)
        lf_edge_after(106); `CHK("edge late", 1'b0, o_edge_valid)
        // Pulsed sync outputs from the first loop, ended by the output tick
        {i_first_loop_fs, i_first_loop_mfs} = 2'b00;
        wr(OFS_SYNC_CFG, 8'h05);
        @(posedge i_clk) #1 i_second_clock_output_tick = 1'b1;
        @(posedge i_clk) #1 i_second_clock_output_tick = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 `CHK("fs idle", 1'b0, o_frame_sync_out)
        `CHK("mfs idle", 1'b0, o_multiframe_sync_out)
        {i_first_loop_fs, i_first_loop_mfs} = 2'b11;
        repeat (2) @(posedge i_clk);
        #1 {i_first_loop_fs, i_first_loop_mfs} = 2'b00;
        repeat (2) @(posedge i_clk);
        #1 `CHK("fs pulse", 1'b1, o_frame_sync_out)
        `CHK("mfs pulse", 1'b1, o_multiframe_sync_out)
        i_second_clock_output_tick = 1'b1;
        @(posedge i_clk) #1 i_second_clock_output_tick = 1'b0;
        @(posedge i_clk) #1 `CHK("fs end", 1'b0, o_frame_sync_out)
        `CHK("mfs end", 1'b0, o_multiframe_sync_out)
        // Alarm after three units, sticky, then software clear and expiry
        wr(OFS_ALARM_CFG, 8'h03);
        @(posedge i_clk) #1 i_unlocked_state = 1'b1;
        repeat (3 * UNIT_SIM - 5) @(posedge i_clk);
        #1 `CHK("alarm early", 1'b0, o_phase_alarm)
        repeat (10) @(posedge i_clk);
        #1 `CHK("alarm due", 1'b1, o_phase_alarm)
        i_unlocked_state = 1'b0;
        repeat (5) @(posedge i_clk);
        #1 `CHK("alarm held", 1'b1, o_phase_alarm)
        i_alarm_clear = 1'b1;
        @(posedge i_clk) #1 i_alarm_clear = 1'b0;
        @(posedge i_clk) #1 `CHK("alarm clear", 1'b0, o_phase_alarm)
        wr(OFS_ALARM_CFG, 8'h00);
        i_unlocked_state = 1'b1;
        repeat (3) @(posedge i_clk);
        #1 {i_unlocked_state, i_alarm_expire_en} = 2'b01;
        `CHK("alarm zero", 1'b1, o_phase_alarm)
        repeat (3) @(posedge i_clk);
        #1 `CHK("alarm expire", 1'b0, o_phase_alarm)
        tally_and_finish();
    end
endmodule : phase_sync_cfg_test
